/* core/reg_guard_consts.svh */
/*
 * constants of the register access guard and preload engine: offsets,
 * failure codes, preload record layout and field widths.
 * assumes it is included by bare name from the package and the design module.
 */
`ifndef REG_GUARD_CONSTS_SVH
`define REG_GUARD_CONSTS_SVH
`define PATH_W          16
`define PORT_W          3
`define ROM_AW          16
`define DW_W            10
`define RANGE_LIMIT     32'h0000_1000
`define FT_NORMAL       4'h0F
`define FT_RANGE        4'h0
`define FT_LOCK         4'h1
`define FT_SW_ROUTE     4'h2
`define PRELOAD_BASE    16'h0100
`define PRELOAD_SIG     5'h10
`define SIZE_END        8'h00
`define CFG_INDEX_OFF   8'h00F8
`define CFG_DATA_OFF    8'h00FC
`define BRIDGE_BASE     12'h0A00
`define RO_SLOT_DW      10'h007A
`define RO_OEM_DW       10'h0008
`define RO_PROTO_DW     10'h0010
`define RO_PROG_DW      10'h001C
`endif

/* core/reg_guard_pkg.sv */
/*
 * types carried between the register access guard and its neighbours.
 * assumes the constants header is on the include path.
 */
`include "reg_guard_consts.svh"
package reg_guard_pkg;
    typedef struct packed {
        logic                is_write;    // else read
        logic                ack_req;     // write wants acknowledge
        logic                multicast;
        logic                config_kind; // configuration-space request
        logic [31:0]         offset;      // byte offset
        logic [3:0]          byte_en;     // active high per byte
        logic [31:0]         wdata;
        logic [`PATH_W-1:0]  path;        // transformed return path
        logic [`PORT_W-1:0]  in_port;
    } req_type;
    typedef struct packed {
        logic                is_read;     // read completion, else write ack
        logic [3:0]          failure;
        logic [31:0]         rdata;
    } rsp_type;
    typedef struct packed {
        logic                enable;
        logic [`PORT_W-1:0]  in_port;
        logic [`PATH_W-1:0]  path;
    } path_entry_type;
    typedef struct packed {
        logic                wr;
        logic                rd;
        logic [`DW_W-1:0]    dw_index;
        logic [3:0]          be;
        logic [31:0]         wdata;
        logic                ro_override; // preload may write read-only bits
    } reg_acc_type;
endpackage : reg_guard_pkg

/* core/register_access_guard_and_preload.sv */
/*
 * register access front end: path protection, range and multicast checks,
 * byte masks, reserved and semaphore handling, response building, and the
 * serial boot memory preload run after reset.
 * assumes the register map answers reg_rdata_i, reg_reserved_i and
 * reg_semaphore_i combinationally from reg_acc_o, and that the memory
 * sequencer is on the same clock and answers rom_valid_i after rom_rd_o.
 */
`timescale 1ns/1ps
`include "reg_guard_consts.svh"
module register_access_guard_and_preload
    import reg_guard_pkg::*;
#(
    parameter int N_PATH = 4
)
(
    // clock and reset
    input  wire logic                 clk_sys_i,
    input  wire logic                 rst_i,
    // request frames
    input  wire logic                 req_valid_i,
    input  wire req_type              req_i,
    output      logic                 req_ready_o,
    // response frames
    output      logic                 rsp_valid_o,
    output      rsp_type              rsp_o,
    // path protection table
    input  wire path_entry_type       path_tab_i [N_PATH],
    // register map port
    output      reg_acc_type          reg_acc_o,
    input  wire logic [31:0]          reg_rdata_i,
    input  wire logic                 reg_reserved_i,
    input  wire logic                 reg_semaphore_i,
    // chip events, one-cycle pulses
    output      logic                 evt_path_prot_o,
    output      logic                 evt_mcast_fail_o,
    output      logic                 evt_range_o,
    // serial boot memory
    input  wire logic                 preload_en_i,
    output      logic                 rom_rd_o,
    output      logic [`ROM_AW-1:0]   rom_addr_o,
    input  wire logic                 rom_valid_i,
    input  wire logic [7:0]           rom_data_i,
    output      logic                 preload_done_o,
    // diagnostic trigger hold-off
    input  wire logic                 diag_trig_i,
    output      logic                 diag_trig_go_o
);

    if (N_PATH != 4)
    begin : g_n_path_check
        $error("path table must have four entries");
    end

    typedef enum {ST_IDLE, ST_ACCESS, ST_RESP} acc_state_type;
    typedef enum {PL_START, PL_SIG, PL_OFS_LO, PL_OFS_HI, PL_SIZE, PL_DATA,
                  PL_DONE} pl_state_type;

    acc_state_type         acc_state_reg;
    pl_state_type          pl_state_reg;
    req_type               req_reg;
    logic [3:0]            fail_reg;
    logic [`DW_W-1:0]      dw_reg;
    logic [31:0]           index_reg;
    logic                  use_index_reg;
    logic                  rom_wait_reg;
    logic [11:0]           pl_ofs_reg;
    logic [7:0]            pl_cnt_reg;

    // checks on the incoming request
    function automatic logic [`DW_W-1:0] dw_of(input logic [31:0] byte_ofs);
        dw_of = byte_ofs[`DW_W+1:2];
    endfunction : dw_of

    function automatic logic is_ro_override(input logic [`DW_W-1:0] dw);
        is_ro_override = (dw == `RO_SLOT_DW) || (dw == `RO_OEM_DW) ||
                         (dw == `RO_PROTO_DW) || (dw == `RO_PROG_DW);
    endfunction : is_ro_override

    logic [N_PATH-1:0] hit_vec;
    logic [N_PATH-1:0] en_vec;
    genvar gi;
    generate
        for (gi = 0; gi < N_PATH; gi++)
        begin : g_path
            assign en_vec[gi]  = path_tab_i[gi].enable;
            assign hit_vec[gi] = path_tab_i[gi].enable &&
                                 path_tab_i[gi].path == req_i.path &&
                                 path_tab_i[gi].in_port == req_i.in_port;
        end
    endgenerate

    logic        idx_hit;
    logic        data_hit;
    logic [31:0] eff_ofs;
    logic        lock_fail;
    logic        mc_fail;
    logic        range_fail;
    logic        take;

    // effective channel offset after the configuration index mechanism
    always_comb
    begin
        idx_hit  = req_i.config_kind && req_i.offset[7:0] == `CFG_INDEX_OFF;
        data_hit = req_i.config_kind && req_i.offset[7:0] == `CFG_DATA_OFF;
        if (data_hit)
            eff_ofs = index_reg;
        else if (req_i.config_kind)
            eff_ofs = {24'h00_0000, req_i.offset[7:0]} + {20'h0_0000, `BRIDGE_BASE};
        else
            eff_ofs = req_i.offset;
        lock_fail  = (|en_vec) && !(|hit_vec);
        mc_fail    = req_i.multicast && req_i.is_write;
        range_fail = eff_ofs >= `RANGE_LIMIT;
    end

    assign take = req_valid_i && req_ready_o;

    // request sequencing; requests wait while preload owns the map
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            acc_state_reg <= ST_IDLE;
            req_reg       <= '0;
            fail_reg      <= `FT_NORMAL;
            dw_reg        <= '0;
            use_index_reg <= 1'b0;
        end
        else
        begin
            case (acc_state_reg)
                ST_IDLE:
                    if (take)
                    begin
                        req_reg       <= req_i;
                        dw_reg        <= dw_of(eff_ofs);
                        use_index_reg <= idx_hit;
                        if (mc_fail)
                            fail_reg <= `FT_SW_ROUTE;
                        else if (lock_fail)
                            fail_reg <= `FT_LOCK;
                        else if (range_fail && !idx_hit)
                            fail_reg <= `FT_RANGE;
                        else
                            fail_reg <= `FT_NORMAL;
                        acc_state_reg <= ST_ACCESS;
                    end
                ST_ACCESS:
                    acc_state_reg <= ST_RESP;
                ST_RESP:
                    acc_state_reg <= ST_IDLE;
                default:
                    acc_state_reg <= ST_IDLE;
            endcase
        end
    end

    // configuration index register, written through configuration space
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
            index_reg <= '0;
        else if (acc_state_reg == ST_ACCESS && use_index_reg && req_reg.is_write
                 && fail_reg == `FT_NORMAL)
        begin
            for (int b = 0; b < 4; b++)
                if (req_reg.byte_en[b])
                    index_reg[8*b +: 8] <= req_reg.wdata[8*b +: 8];
        end
    end

    // register map strobes from either the request path or the preload
    logic pl_wr;
    assign pl_wr = pl_state_reg == PL_DATA && rom_valid_i && rom_wait_reg;

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
            reg_acc_o <= '0;
        else if (pl_wr)
        begin
            reg_acc_o.wr          <= 1'b1;
            reg_acc_o.rd          <= 1'b0;
            reg_acc_o.dw_index    <= pl_ofs_reg[`DW_W+1:2];
            reg_acc_o.be          <= 4'h1 << pl_ofs_reg[1:0];
            reg_acc_o.wdata       <= {4{rom_data_i}};
            reg_acc_o.ro_override <= is_ro_override(pl_ofs_reg[`DW_W+1:2]);
        end
        else if (take && !mc_fail && !lock_fail && !range_fail && !idx_hit)
        begin
            // reads fetch the whole dword unless every byte is masked
            reg_acc_o.wr          <= req_i.is_write;
            reg_acc_o.rd          <= !req_i.is_write;
            reg_acc_o.dw_index    <= dw_of(eff_ofs);
            reg_acc_o.be          <= (req_i.is_write || req_i.byte_en == 4'h0) ?
                                     req_i.byte_en : 4'hF;
            reg_acc_o.wdata       <= req_i.wdata;
            reg_acc_o.ro_override <= 1'b0;
        end
        else
            reg_acc_o <= '0;
    end

    // all-masked reads reach the map with no byte enabled, so no side effect fires
    logic sem_skip;
    assign sem_skip = reg_semaphore_i && req_reg.byte_en == 4'h0;

    // response frame: one per read, one per acknowledged write
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            rsp_valid_o <= 1'b0;
            rsp_o       <= '0;
        end
        else if (acc_state_reg == ST_ACCESS)
        begin
            rsp_valid_o   <= !req_reg.is_write || req_reg.ack_req;
            rsp_o.is_read <= !req_reg.is_write;
            rsp_o.failure <= fail_reg;
            if (fail_reg != `FT_NORMAL || req_reg.is_write)
                rsp_o.rdata <= '0;
            else if (use_index_reg)
                rsp_o.rdata <= index_reg;
            else if (reg_reserved_i || sem_skip)
                rsp_o.rdata <= '0;
            else
                rsp_o.rdata <= reg_rdata_i;
        end
        else
            rsp_valid_o <= 1'b0;
    end

    // chip events raised at acceptance
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            evt_path_prot_o  <= 1'b0;
            evt_mcast_fail_o <= 1'b0;
            evt_range_o      <= 1'b0;
        end
        else
        begin
            evt_mcast_fail_o <= take && mc_fail;
            evt_path_prot_o  <= take && !mc_fail && lock_fail;
            evt_range_o      <= take && !mc_fail && !lock_fail && range_fail
                                && !req_i.config_kind;
        end
    end

    // request port opens only when idle and preload has finished
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
            req_ready_o <= 1'b0;
        else
            req_ready_o <= pl_state_reg == PL_DONE && acc_state_reg == ST_IDLE
                           && !take;
    end

    // preload record parser
    logic rom_byte;
    assign rom_byte = rom_valid_i && rom_wait_reg;

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            pl_state_reg <= PL_START;
            pl_ofs_reg   <= '0;
            pl_cnt_reg   <= '0;
        end
        else
        begin
            case (pl_state_reg)
                PL_START:
                    pl_state_reg <= preload_en_i ? PL_SIG : PL_DONE;
                PL_SIG:
                    if (rom_byte)
                        pl_state_reg <= rom_data_i[7:3] == `PRELOAD_SIG ?
                                        PL_OFS_LO : PL_DONE;
                PL_OFS_LO:
                    if (rom_byte)
                        pl_ofs_reg[7:0] <= rom_data_i;
                PL_OFS_HI:
                    if (rom_byte)
                        pl_ofs_reg[11:8] <= rom_data_i[3:0];
                PL_SIZE:
                    if (rom_byte)
                    begin
                        pl_cnt_reg <= rom_data_i;
                        if (rom_data_i == `SIZE_END)
                            pl_state_reg <= PL_DONE;
                    end
                PL_DATA:
                    if (rom_byte)
                    begin
                        pl_ofs_reg <= pl_ofs_reg + 12'h001;
                        pl_cnt_reg <= pl_cnt_reg - 8'h01;
                        if (pl_cnt_reg == 8'h01)
                            pl_state_reg <= PL_OFS_LO;
                    end
                PL_DONE:
                    pl_state_reg <= PL_DONE;
                default:
                    pl_state_reg <= PL_DONE;
            endcase
            if (rom_byte && pl_state_reg == PL_OFS_LO)
                pl_state_reg <= PL_OFS_HI;
            if (rom_byte && pl_state_reg == PL_OFS_HI)
                pl_state_reg <= PL_SIZE;
            if (rom_byte && pl_state_reg == PL_SIZE && rom_data_i != `SIZE_END)
                pl_state_reg <= PL_DATA;
        end
    end

    // memory byte fetch, one outstanding read at a time
    logic pl_reading;
    assign pl_reading = pl_state_reg != PL_START && pl_state_reg != PL_DONE;

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            rom_rd_o     <= 1'b0;
            rom_addr_o   <= `PRELOAD_BASE;
            rom_wait_reg <= 1'b0;
        end
        else
        begin
            rom_rd_o <= 1'b0;
            if (rom_byte)
            begin
                rom_wait_reg <= 1'b0;
                rom_addr_o   <= rom_addr_o + 16'h0001;
            end
            else if (pl_reading && !rom_wait_reg && !rom_rd_o)
            begin
                rom_rd_o     <= 1'b1;
                rom_wait_reg <= 1'b1;
            end
        end
    end

    // preload status and diagnostic trigger hold-off
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            preload_done_o <= 1'b0;
            diag_trig_go_o <= 1'b0;
        end
        else
        begin
            preload_done_o <= pl_state_reg == PL_DONE;
            diag_trig_go_o <= diag_trig_i && pl_state_reg == PL_DONE;
        end
    end

endmodule : register_access_guard_and_preload

/* dv/reg_guard_asserts.sv */
/*
 * checker for the register access guard: answer timing, refusals, preload.
 * assumes it is bound to the guard and sees only the guard's ports.
 */
`timescale 1ns/1ps
`include "reg_guard_consts.svh"
module reg_guard_asserts
    import reg_guard_pkg::*;
#(
    parameter int N_PATH = 4
)
(
    // clock and reset
    input wire logic               clk_sys_i,
    input wire logic               rst_i,
    // request, response and path table
    input wire logic               req_valid_i,
    input wire req_type            req_i,
    input wire logic               req_ready_o,
    input wire logic               rsp_valid_o,
    input wire rsp_type            rsp_o,
    input wire path_entry_type     path_tab_i [N_PATH],
    // map strobes and events
    input wire reg_acc_type        reg_acc_o,
    input wire logic               evt_path_prot_o,
    input wire logic               evt_mcast_fail_o,
    input wire logic               evt_range_o,
    // preload and trigger hold-off
    input wire logic               rom_rd_o,
    input wire logic [`ROM_AW-1:0] rom_addr_o,
    input wire logic               preload_done_o,
    input wire logic               diag_trig_i,
    input wire logic               diag_trig_go_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    logic               tk, any_en, hit, gp, ok;
    logic [`ROM_AW-1:0] nxt_addr;
    // path match over every enabled entry, the way a request is judged
    always_comb
    begin
        any_en = 1'b0;
        hit = 1'b0;
        for (int i = 0; i < N_PATH; i++)
            if (path_tab_i[i].enable)
            begin
                any_en = 1'b1;
                hit |= path_tab_i[i].path == req_i.path && path_tab_i[i].in_port == req_i.in_port;
            end
    end
    // taken non-multicast, non-configuration requests that pass the path check
    assign tk = req_valid_i && req_ready_o;
    assign gp = tk && !req_i.multicast && !req_i.config_kind && (!any_en || hit);
    assign ok = gp && req_i.offset < `RANGE_LIMIT;
    // next memory address expected; restarts at the record base on reset
    always_ff @(posedge clk_sys_i)
        if (rst_i)
            nxt_addr <= `PRELOAD_BASE;
        else if (rom_rd_o)
            nxt_addr <= rom_addr_o + 16'h0001;
    // the request properties tie an output to its cause with the exact spacing
    property p_rsp; tk && (!req_i.is_write || req_i.ack_req) |-> ##2 rsp_valid_o; endproperty
    a_rsp: assert property (p_rsp) else $error("response missing");
    property p_nors; tk && req_i.is_write && !req_i.ack_req |-> ##2 !rsp_valid_o; endproperty
    a_nors: assert property (p_nors) else $error("response not asked for");
    property p_one; rsp_valid_o |=> !rsp_valid_o [*3]; endproperty
    a_one: assert property (p_one) else $error("extra completion");
    property p_wr; ok && req_i.is_write |=> reg_acc_o.wr && reg_acc_o.be == $past(req_i.byte_en)
        && reg_acc_o.dw_index == $past(req_i.offset[11:2])
        ##1 (!rsp_valid_o || rsp_o.failure == `FT_NORMAL); endproperty
    a_wr: assert property (p_wr) else $error("write strobe or code wrong");
    property p_rd; ok && !req_i.is_write |=> reg_acc_o.rd
        && reg_acc_o.be == ($past(req_i.byte_en) == 4'h0 ? 4'h0 : 4'hF); endproperty
    a_rd: assert property (p_rd) else $error("read byte mask wrong");
    property p_lock; tk && !req_i.multicast && any_en && !hit |=> evt_path_prot_o
        && !reg_acc_o.wr && !reg_acc_o.rd ##1 (!rsp_valid_o || rsp_o.failure == `FT_LOCK); endproperty
    a_lock: assert property (p_lock) else $error("path lock not enforced");
    property p_mcast; tk && req_i.is_write && req_i.multicast |=> evt_mcast_fail_o
        && !reg_acc_o.wr ##1 (!rsp_valid_o || rsp_o.failure == `FT_SW_ROUTE); endproperty
    a_mcast: assert property (p_mcast) else $error("multicast write not refused");
    property p_range; gp && req_i.offset >= `RANGE_LIMIT |=> evt_range_o && !reg_acc_o.wr
        && !reg_acc_o.rd ##1 (!rsp_valid_o || rsp_o.failure == `FT_RANGE); endproperty
    a_range: assert property (p_range) else $error("range error missed");
    property p_ready; req_ready_o |-> preload_done_o; endproperty
    a_ready: assert property (p_ready) else $error("request taken during preload");
    property p_rom; rom_rd_o |-> rom_addr_o == nxt_addr; endproperty
    a_rom: assert property (p_rom) else $error("memory address out of sequence");
    property p_pl; !preload_done_o |-> !reg_acc_o.rd && (!reg_acc_o.wr || ($onehot(reg_acc_o.be)
        && reg_acc_o.wdata == {4{reg_acc_o.wdata[7:0]}})); endproperty
    a_pl: assert property (p_pl) else $error("preload access malformed");
    property p_ro; reg_acc_o.wr && !preload_done_o && reg_acc_o.dw_index inside {`RO_SLOT_DW,
        `RO_OEM_DW, `RO_PROTO_DW, `RO_PROG_DW} |-> reg_acc_o.ro_override; endproperty
    a_ro: assert property (p_ro) else $error("read-only override missing");
    property p_diag; diag_trig_go_o |-> preload_done_o && $past(diag_trig_i); endproperty
    a_diag: assert property (p_diag) else $error("trigger passed before preload end");
endmodule : reg_guard_asserts

/* dv/map_rom_model.sv */
/*
 * far side: a small register map and the serial boot memory.
 * assumes the guard's map and memory ports on the one system clock.
 */
`timescale 1ns/1ps
module map_rom_model
    import reg_guard_pkg::*;
(
    // clock
    input  wire logic        clk_sys_i,
    // register map
    input  wire reg_acc_type reg_acc_o,
    output      logic [31:0] reg_rdata_i,
    output      logic        reg_reserved_i,
    output      logic        reg_semaphore_i,
    // serial boot memory
    input  wire logic        rom_rd_o,
    input  wire logic [15:0] rom_addr_o,
    output      logic        rom_valid_i,
    output      logic [7:0]  rom_data_i
);
    logic [31:0] mem [16];
    logic [7:0]  rom [512];
    logic [8:0]  a;
    logic        slow = 1'b0;
    // answers follow the strobe index at once; 16 dwords alias the map
    assign reg_rdata_i = mem[reg_acc_o.dw_index[3:0]];
    assign reg_reserved_i = reg_acc_o.dw_index == 10'h006;
    assign reg_semaphore_i = reg_acc_o.dw_index[9:3] == 7'h60;
    // nonzero fill, so a wrongly passed reserved read shows
    initial
    begin
        foreach (mem[i])
            mem[i] = 32'hDEAD_BEEF;
        foreach (rom[i])
            rom[i] = 8'h5A;
        rom_valid_i = 1'b0;
        rom_data_i = 8'h00;
    end
    // lane writes only; masking is the guard's job
    always @(posedge clk_sys_i)
        if (reg_acc_o.wr === 1'b1)
            for (int b = 0; b < 4; b++)
                if (reg_acc_o.be[b])
                    mem[reg_acc_o.dw_index[3:0]][8*b+:8] <= reg_acc_o.wdata[8*b+:8];
    // alternately prompt and three cycles late; idle data is the inverse
    always @(posedge clk_sys_i)
        if (rom_rd_o === 1'b1)
        begin
            a = rom_addr_o[8:0];
            repeat (slow ? 3 : 0) @(posedge clk_sys_i);
            #1 rom_valid_i = 1'b1;
            rom_data_i = rom[a];
            @(posedge clk_sys_i);
            #1 rom_valid_i = 1'b0;
            rom_data_i = ~rom_data_i;
            slow = ~slow;
        end
endmodule : map_rom_model

/* dv/tb_top.sv */
/*
 * self-checking bench for the register access guard and preload engine.
 * assumes the package, the design, the checker and the far-side model.
 */
`timescale 1ns/1ps
module tb_top import reg_guard_pkg::*;;
    localparam logic [3:0] W = 4'h8, A = 4'h4, M = 4'h2, C = 4'h1;
    logic           clk_sys_i = 1'b0, rst_i = 1'b1, req_valid_i = 1'b0;
    logic           preload_en_i = 1'b1, diag_trig_i = 1'b0, reg_reserved_i, reg_semaphore_i;
    logic           req_ready_o, rsp_valid_o, rom_rd_o, rom_valid_i, preload_done_o;
    logic           evt_path_prot_o, evt_mcast_fail_o, evt_range_o, diag_trig_go_o;
    logic [31:0]    reg_rdata_i;
    logic [15:0]    rom_addr_o, g_path, st = 16'h000E, ds = 16'h000E;
    logic [7:0]     rom_data_i;
    logic [7:0]     img [13] = '{8'h80, 8'h20, 8'h00, 8'h02, 8'hAA, 8'hBB, 8'h73,
                                 8'h08, 8'h01, 8'hCC, 8'h00, 8'h00, 8'h00};
    logic [2:0]     g_port;
    req_type        req_i = '0;
    rsp_type        rsp_o;
    reg_acc_type    reg_acc_o;
    path_entry_type path_tab_i [4];
    rsp_type        q [$];
    int             failures = 0, cmp_count = 0;
    always #50 clk_sys_i = ~clk_sys_i;
    register_access_guard_and_preload #(.N_PATH(4)) dut_u (.clk_sys_i, .rst_i, .req_valid_i,
        .req_i, .req_ready_o, .rsp_valid_o, .rsp_o, .path_tab_i, .reg_acc_o, .reg_rdata_i,
        .reg_reserved_i, .reg_semaphore_i, .evt_path_prot_o, .evt_mcast_fail_o, .evt_range_o,
        .preload_en_i, .rom_rd_o, .rom_addr_o, .rom_valid_i, .rom_data_i, .preload_done_o,
        .diag_trig_i, .diag_trig_go_o);
    map_rom_model mdl_u (.clk_sys_i, .reg_acc_o, .reg_rdata_i, .reg_reserved_i,
        .reg_semaphore_i, .rom_rd_o, .rom_addr_o, .rom_valid_i, .rom_data_i);
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    function automatic rsp_type rx(input logic [3:0] f, input logic [31:0] d);
        return {1'b1, f, d};
    endfunction : rx
    function automatic rsp_type wa(input logic [3:0] f);
        return {1'b0, f, 32'h0000_0000};
    endfunction : wa
    task automatic check(input logic [36:0] seen, input logic [36:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic results;
        $display("comparisons %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : results
    // one single-dword request, held until taken; a due answer is noted
    task automatic rq(input logic [3:0] f, input logic [31:0] ofs, input logic [3:0] be,
                      input logic [31:0] d, input rsp_type e);
        int n;
        @(posedge clk_sys_i);
        #1 req_i = '{f[3], f[2], f[1], f[0], ofs, be, d, g_path, g_port};
        req_valid_i = 1'b1;
        n = 0;
        do
            @(posedge clk_sys_i);
        while (req_ready_o !== 1'b1 && ++n < 50);
        if (!f[3] || f[2])
            q.push_back(e);
        #1 req_valid_i = 1'b0;
        failures += (n >= 50);
    endtask : rq
    // let a due answer out, reset six cycles, then a bounded preload wait
    task automatic rs(input logic en);
        int n;
        repeat (2) @(posedge clk_sys_i);
        #1 preload_en_i = en;
        rst_i = 1'b1;
        repeat (6) @(posedge clk_sys_i);
        #1 rst_i = 1'b0;
        for (n = 0; preload_done_o !== 1'b1 && n < 3000; n++)
            @(posedge clk_sys_i);
        #1 check(37'(preload_done_o), 37'h1);
    endtask : rs
    // responses compared in order; write acks carry no data to judge
    always @(posedge clk_sys_i)
        if (rsp_valid_o === 1'b1)
        begin
            rsp_type     e;
            logic [36:0] s;
            e = q.size() ? q.pop_front() : '1;
            s = {rsp_o.is_read, rsp_o.failure, e.is_read ? rsp_o.rdata : e.rdata};
            check(s, e);
        end
    // random trigger requests, also while the preload runs
    always @(posedge clk_sys_i)
    begin
        #1 ds = lfsr(ds);
        diag_trig_i = ds[0];
    end
    // hang guard, well beyond the expected few hundred cycles
    initial
    begin
        #2_000_000;
        failures++;
        results();
    end
    initial
    begin
        foreach (path_tab_i[i])
            path_tab_i[i] = '0;
        g_path = 16'h1234;
        g_port = 3'h2;
        #1;
        foreach (img[i])
            mdl_u.rom[256 + i] = img[i];
        rs(1'b1);
        rq(W | A, 32'h40, 4'h5, 32'h1122_3344, wa(4'hF));
        rq(4'h0, 32'h40, 4'h1, 32'h0, rx(4'hF, 32'hDE22_BE44));
        rq(4'h0, 32'h20, 4'hF, 32'h0, rx(4'hF, 32'hDEAD_BBAA));
        rq(4'h0, 32'h870, 4'hF, 32'h0, rx(4'hF, 32'hCCAD_BEEF));
        rq(4'h0, 32'h18, 4'hF, 32'h0, rx(4'hF, 32'h0));
        rq(4'h0, 32'hC04, 4'h0, 32'h0, rx(4'hF, 32'h0));
        rq(W | C, 32'hF8, 4'hF, 32'h40, wa(4'hF));
        rq(C, 32'hFC, 4'hF, 32'h0, rx(4'hF, 32'hDE22_BE44));
        rq(4'h0, 32'hFFC, 4'hF, 32'h0, rx(4'hF, 32'hDEAD_BEEF));
        rq(4'h0, 32'h1000, 4'hF, 32'h0, rx(4'h0, 32'h0));
        rq(W | A, 32'h1FFC, 4'hF, 32'h1, wa(4'h0));
        rq(W | A | M, 32'h40, 4'hF, 32'h1, wa(4'h2));
        rq(4'h0, 32'h40, 4'hF, 32'h0, rx(4'hF, 32'hDE22_BE44));
        path_tab_i[2] = '{1'b1, 3'h2, 16'h1234};
        path_tab_i[3] = '{1'b1, 3'h5, 16'h00FF};
        rq(W | A, 32'h44, 4'hF, 32'h5555_AAAA, wa(4'hF));
        g_port = 3'h3;
        rq(W | A, 32'h44, 4'hF, 32'h0, wa(4'h1));
        rq(C, 32'hFC, 4'hF, 32'h0, rx(4'h1, 32'h0));
        g_path = 16'h00FF;
        g_port = 3'h5;
        rq(4'h0, 32'h44, 4'hF, 32'h0, rx(4'hF, 32'h5555_AAAA));
        for (int i = 0; i < 4; i++)
        begin
            st = lfsr(st);
            rq(W | (i[0] ? A : 4'h0), 32'(256 + 4 * i), 4'hF, {st, ~st}, wa(4'hF));
            rq(4'h0, 32'(256 + 4 * i), 4'hF, 32'h0, rx(4'hF, {st, ~st}));
        end
        // preload switched off, then a bad mark: neither may touch the map
        for (int k = 0; k < 2; k++)
        begin
            mdl_u.rom[256] = k ? 8'h88 : 8'h80;
            mdl_u.rom[260] = 8'h11;
            rs(k[0]);
            rq(4'h0, 32'h20, 4'hF, 32'h0, rx(4'hF, 32'hDEAD_BBAA));
        end
        repeat (4) @(posedge clk_sys_i);
        check(37'(q.size()), 37'h0);
        results();
    end
endmodule : tb_top
bind register_access_guard_and_preload reg_guard_asserts #(.N_PATH(N_PATH)) chk_u (.clk_sys_i,
    .rst_i, .req_valid_i, .req_i, .req_ready_o, .rsp_valid_o, .rsp_o, .path_tab_i, .reg_acc_o,
    .evt_path_prot_o, .evt_mcast_fail_o, .evt_range_o, .rom_rd_o, .rom_addr_o, .preload_done_o,
    .diag_trig_i, .diag_trig_go_o);
